/* verilog/cec_defs.svh */
`ifndef CEC_DEFS_SVH
`define CEC_DEFS_SVH
`define CEC_ADDR_CONTROL      8'h9e
`define CEC_ADDR_INPUT_SEL    8'h9f
`define CEC_CONTROL_RESET     8'h00
`define CEC_INPUT_SEL_RESET   8'h00
`define CEC_BIT_RUN_IDLE      7
`define CEC_BIT_RUN_PD        6
`define CEC_BIT_RESULT        5
`define CEC_BIT_FLAG          4
`define CEC_BIT_ENABLE        3
`define CEC_COND_MSB          2
`define CEC_COND_LSB          0
`define CEC_NEG_MSB           7
`define CEC_NEG_LSB           4
`define CEC_POS_MSB           1
`define CEC_POS_LSB           0
`define CEC_INPUT_SEL_WMASK   8'hf3
`define CEC_IE_IRQ_BIT        6
`define CEC_DEBOUNCE_PULSES   2'h2
`define CEC_SETTLE_US         10
`define CEC_SETTLE_CYCLES     (`CEC_SETTLE_US * 125)
`endif

/* verilog/cec_pkg.sv */
package cec_pkg;
    typedef enum logic [2:0] {
        CEC_LOW_LEVEL   = 3'h0,
        CEC_RISE        = 3'h1,
        CEC_TOGGLE_DB   = 3'h2,
        CEC_RISE_DB     = 3'h3,
        CEC_FALL        = 3'h4,
        CEC_TOGGLE      = 3'h5,
        CEC_FALL_DB     = 3'h6,
        CEC_HIGH_LEVEL  = 3'h7
    } cec_cond_e;
    typedef enum logic [1:0] {
        CEC_DB_IDLE,
        CEC_DB_WAIT,
        CEC_DB_CHECK
    } cec_db_state_e;
endpackage : cec_pkg

/* verilog/cec_sync.sv */
module cec_sync (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic async_in,
    output logic      sync_out
);
    logic stage1_reg;
    logic stage1_next;
    logic stage2_reg;
    logic stage2_next;

    always_comb begin
        stage1_next = async_in;
        stage2_next = stage1_reg;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
        end else begin
            stage1_reg <= stage1_next;
            stage2_reg <= stage2_next;
        end
    end

    assign sync_out = stage2_reg;
endmodule : cec_sync

/* verilog/cec_debounce.sv */
`include "cec_defs.svh"
module cec_debounce (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic start,
    input  wire logic expected,
    input  wire logic sample,
    input  wire logic tick,
    input  wire logic abort,
    output logic      hit
);
    import cec_pkg::*;
    cec_db_state_e state_reg;
    cec_db_state_e state_next;
    logic [1:0]    count_reg;
    logic [1:0]    count_next;
    logic          exp_reg;
    logic          exp_next;
    logic          hit_reg;
    logic          hit_next;

    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        exp_next   = exp_reg;
        hit_next   = 1'b0;
        unique case (state_reg)
            CEC_DB_IDLE: begin
                if (start) begin
                    state_next = CEC_DB_WAIT;
                    count_next = 2'h0;
                    exp_next   = expected;
                end
            end
            CEC_DB_WAIT: begin
                // Free-running timer: two overflows give at least one full period
                if (tick) begin
                    count_next = count_reg + 2'h1;
                    if (count_reg + 2'h1 == `CEC_DEBOUNCE_PULSES) begin
                        state_next = CEC_DB_CHECK;
                    end
                end
            end
            CEC_DB_CHECK: begin
                hit_next   = (sample == exp_reg);
                state_next = CEC_DB_IDLE;
            end
            default: state_next = CEC_DB_IDLE;
        endcase
        if (abort) begin
            state_next = CEC_DB_IDLE;
            hit_next   = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= CEC_DB_IDLE;
            count_reg <= 2'h0;
            exp_reg   <= 1'b0;
            hit_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            exp_reg   <= exp_next;
            hit_reg   <= hit_next;
        end
    end

    assign hit = hit_reg;

    a_db_two_ticks: assert property (@(posedge clk) disable iff (!arst_n)
        (state_reg == CEC_DB_CHECK) |-> ($past(state_reg) == CEC_DB_WAIT && $past(tick)))
        else $error("debounce check without second overflow");
endmodule : cec_debounce

/* verilog/cec_top.sv */
`include "cec_defs.svh"
module cec_top (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    input  wire logic [7:0] interrupt_enable_reg,
    input  wire logic       idle_mode,
    input  wire logic       powerdown_mode,
    input  wire logic       timer1_overflow,
    input  wire logic       analog_compare_raw,
    input  wire logic       level_compare_raw,
    output logic [1:0]      positive_source_sel,
    output logic [3:0]      negative_source_sel,
    output logic            analog_enable,
    output logic            compare_irq,
    output logic            wake_request
);
    import cec_pkg::*;
    logic [7:0] control_reg;
    logic [7:0] control_next;
    logic [7:0] input_sel_reg;
    logic [7:0] input_sel_next;
    logic       prev_reg;
    logic       prev_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic       irq_reg;
    logic       irq_next;
    logic       wake_reg;
    logic       wake_next;
    logic       analog_en_reg;
    logic       analog_en_next;
    logic       cmp_sync;
    logic       lvl_sync;
    logic       db_hit;
    logic       running;
    logic       enabled;
    logic       cmp_gated;
    logic       rise;
    logic       fall;
    logic       plain_event;
    logic       db_start;
    logic       db_expected;
    logic       event_set;
    logic       level_mode;
    logic       lvl_match;
    cec_cond_e  cond;

    // Synchronise before any evaluation; the analog core does the compare and muxing
    cec_sync u_sync_cmp (
        .clk      (clk),
        .arst_n   (arst_n),
        .async_in (analog_compare_raw),
        .sync_out (cmp_sync)
    );
    cec_sync u_sync_lvl (
        .clk      (clk),
        .arst_n   (arst_n),
        .async_in (level_compare_raw),
        .sync_out (lvl_sync)
    );

    always_comb begin
        cond       = cec_cond_e'(control_reg[`CEC_COND_MSB:`CEC_COND_LSB]);
        enabled    = control_reg[`CEC_BIT_ENABLE];
        // Gated off in low power unless allowed
        running    = enabled
                     && !(idle_mode && !control_reg[`CEC_BIT_RUN_IDLE])
                     && !(powerdown_mode && !control_reg[`CEC_BIT_RUN_PD]);
        cmp_gated  = running & cmp_sync;
        rise       = cmp_gated & ~prev_reg;
        fall       = ~cmp_gated & prev_reg;
        level_mode = (cond == CEC_LOW_LEVEL) || (cond == CEC_HIGH_LEVEL);
        plain_event = 1'b0;
        db_start    = 1'b0;
        db_expected = cmp_gated;
        unique case (cond)
            CEC_LOW_LEVEL:  plain_event = ~cmp_gated;
            CEC_HIGH_LEVEL: plain_event = cmp_gated;
            CEC_RISE:       plain_event = rise;
            CEC_FALL:       plain_event = fall;
            CEC_TOGGLE:     plain_event = rise | fall;
            CEC_TOGGLE_DB:  db_start    = rise | fall;
            CEC_RISE_DB:    db_start    = rise;
            CEC_FALL_DB:    db_start    = fall;
        endcase
        event_set = running && (plain_event || db_hit);
    end

    cec_debounce u_debounce (
        .clk      (clk),
        .arst_n   (arst_n),
        .start    (db_start && running),
        .expected (db_expected),
        .sample   (cmp_gated),
        .tick     (timer1_overflow),
        .abort    (!running),
        .hit      (db_hit)
    );

    always_comb begin
        control_next   = control_reg;
        input_sel_next = input_sel_reg;
        if (sfr_wr && sfr_addr == `CEC_ADDR_CONTROL) begin
            control_next = sfr_wdata;
        end
        if (sfr_wr && sfr_addr == `CEC_ADDR_INPUT_SEL) begin
            input_sel_next = sfr_wdata & `CEC_INPUT_SEL_WMASK;
        end
        control_next[`CEC_BIT_RESULT] = cmp_gated;
        // Set beats a same-cycle software clear
        if (event_set) begin
            control_next[`CEC_BIT_FLAG] = 1'b1;
        end
        prev_next = cmp_gated;
        rdata_next = 8'h00;
        if (sfr_addr == `CEC_ADDR_CONTROL) begin
            rdata_next = control_reg;
        end else if (sfr_addr == `CEC_ADDR_INPUT_SEL) begin
            rdata_next = input_sel_reg;
        end
        irq_next = control_reg[`CEC_BIT_FLAG] && interrupt_enable_reg[`CEC_IE_IRQ_BIT];
        // Only level conditions survive in power-down: no clock for edges
        wake_next = irq_next
                    && ((idle_mode && control_reg[`CEC_BIT_RUN_IDLE] && enabled)
                        || (powerdown_mode && control_reg[`CEC_BIT_RUN_PD] && enabled
                            && level_mode));
        analog_en_next = running;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            control_reg   <= `CEC_CONTROL_RESET;
            input_sel_reg <= `CEC_INPUT_SEL_RESET;
            prev_reg      <= 1'b0;
            rdata_reg     <= 8'h00;
            irq_reg       <= 1'b0;
            wake_reg      <= 1'b0;
            analog_en_reg <= 1'b0;
        end else begin
            control_reg   <= control_next;
            input_sel_reg <= input_sel_next;
            prev_reg      <= prev_next;
            rdata_reg     <= rdata_next;
            irq_reg       <= irq_next;
            wake_reg      <= wake_next;
            analog_en_reg <= analog_en_next;
        end
    end

    assign sfr_rdata           = rdata_reg;
    assign positive_source_sel = input_sel_reg[`CEC_POS_MSB:`CEC_POS_LSB];
    assign negative_source_sel = input_sel_reg[`CEC_NEG_MSB:`CEC_NEG_LSB];
    assign analog_enable       = analog_en_reg;
    assign compare_irq         = irq_reg;
    assign wake_request        = wake_reg;

    a_flag_sticks: assert property (@(posedge clk) disable iff (!arst_n)
        event_set |=> control_reg[`CEC_BIT_FLAG])
        else $error("event did not set flag");
    a_flag_hold: assert property (@(posedge clk) disable iff (!arst_n)
        (control_reg[`CEC_BIT_FLAG] && !(sfr_wr && sfr_addr == `CEC_ADDR_CONTROL))
        |=> control_reg[`CEC_BIT_FLAG])
        else $error("flag lost without clear");
    a_disabled_quiet: assert property (@(posedge clk) disable iff (!arst_n)
        (!control_reg[`CEC_BIT_ENABLE] && !(sfr_wr && sfr_addr == `CEC_ADDR_CONTROL))
        |=> !control_reg[`CEC_BIT_RESULT])
        else $error("result not low while disabled");
    a_result_ro: assert property (@(posedge clk) disable iff (!arst_n)
        1'b1 |=> control_reg[`CEC_BIT_RESULT] == $past(cmp_gated))
        else $error("result bit not from comparator");
    a_irq_gate: assert property (@(posedge clk) disable iff (!arst_n)
        compare_irq |-> $past(interrupt_enable_reg[`CEC_IE_IRQ_BIT]))
        else $error("irq without enable");
    a_level_reset: assert property (@(posedge clk) disable iff (!arst_n)
        (running && cond == CEC_HIGH_LEVEL && cmp_sync) |=> control_reg[`CEC_BIT_FLAG])
        else $error("level not re-setting flag");
    a_pd_wake_level: assert property (@(posedge clk) disable iff (!arst_n)
        (wake_request && $past(powerdown_mode) && !$past(idle_mode)) |-> $past(level_mode))
        else $error("power-down wake in edge mode");
    a_rise_sets: assert property (@(posedge clk) disable iff (!arst_n)
        (running && cond == CEC_RISE && rise) |=> control_reg[`CEC_BIT_FLAG])
        else $error("rising edge missed");
    a_idle_gate: assert property (@(posedge clk) disable iff (!arst_n)
        (idle_mode && !control_reg[`CEC_BIT_RUN_IDLE]) |=> !analog_enable)
        else $error("running in idle when gated");
endmodule : cec_top

/* sim/cec_cpu_model.sv */
`include "cec_defs.svh"
module cec_cpu_model (
    input  wire logic       clk,
    output logic            sfr_wr,
    output logic      [7:0] sfr_addr,
    output logic      [7:0] sfr_wdata,
    output logic      [7:0] interrupt_enable_reg
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        sfr_wr               = 1'b0;
        sfr_addr             = 8'h00;
        sfr_wdata            = 8'h00;
        interrupt_enable_reg = 8'h00;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_wr    = 1'b1;
        sfr_addr  = a;
        sfr_wdata = d;
        @(negedge clk);
        sfr_wr    = 1'b0;
        sfr_wdata = ~d; // Stale data must not look valid
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(negedge clk);
        sfr_addr = a;
    endtask : rd

    task automatic ie_set(input logic [7:0] v);
        @(negedge clk);
        interrupt_enable_reg = v;
    endtask : ie_set

    // Output unstable just after enable, so wait and clear first
    task automatic irq_on(input logic [7:0] ctl);
        repeat (`CEC_SETTLE_CYCLES) @(negedge clk);
        wr(`CEC_ADDR_CONTROL, ctl & 8'hef);
        ie_set(8'h01 << `CEC_IE_IRQ_BIT);
    endtask : irq_on
endmodule : cec_cpu_model

/* sim/test_comparator_event_control.sv */
`include "cec_defs.svh"
module test_comparator_event_control;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        sfr_wr;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, interrupt_enable_reg, v;
    logic        idle_mode = 1'b0, powerdown_mode = 1'b0, timer1_overflow = 1'b0, raw = 1'b0;
    logic [1:0]  positive_source_sel;
    logic [3:0]  negative_source_sel;
    logic        analog_enable, compare_irq, wake_request, due = 1'b0;
    logic [16:0] exp_q[$], msk_q[$], e, m;
    int          fail_count = 0, cmp_count = 0, seed = 72912;

    always #4 clk = ~clk;

    cec_cpu_model u_cec_cpu_model (.clk(clk), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .interrupt_enable_reg(interrupt_enable_reg));
    cec_top u_cec_top (.clk(clk), .arst_n(arst_n), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .interrupt_enable_reg(interrupt_enable_reg), .idle_mode(idle_mode),
        .powerdown_mode(powerdown_mode), .timer1_overflow(timer1_overflow), .analog_compare_raw(raw),
        .level_compare_raw(raw), .positive_source_sel(positive_source_sel),
        .negative_source_sel(negative_source_sel), .analog_enable(analog_enable), .compare_irq(compare_irq),
        .wake_request(wake_request));

    task automatic check(input logic [16:0] seen, input logic [16:0] want);
        cmp_count++;
        if (seen !== want) begin
            fail_count++;
            $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
        end
    endtask : check

    task automatic end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_of_test

    // Expectation queued here, compared by the watcher below
    task automatic note(input logic [16:0] ex, input logic [16:0] mk);
        @(posedge clk);
        exp_q.push_back(ex);
        msk_q.push_back(mk);
        due = 1'b1;
        @(negedge clk);
    endtask : note

    always @(negedge clk) begin
        if (due) begin
            due = 1'b0;
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            check({sfr_rdata, compare_irq, wake_request, analog_enable, positive_source_sel,
                   negative_source_sel} & m, e & m);
        end
    end

    task automatic rdc(input logic [7:0] a, input logic [7:0] x);
        u_cec_cpu_model.rd(a);
        note({x, 9'h000}, 17'h1fe00);
    endtask : rdc

    task automatic outc(input logic [2:0] iwa, input logic [2:0] mk);
        note({8'h00, iwa, 6'h00}, {8'h00, mk, 6'h00});
    endtask : outc

    task automatic wc(input logic [7:0] d);
        u_cec_cpu_model.wr(`CEC_ADDR_CONTROL, d);
    endtask : wc

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    task automatic setraw(input logic b);
        @(negedge clk);
        raw = b;
    endtask : setraw

    task automatic tick;
        @(negedge clk);
        timer1_overflow = 1'b1;
        @(negedge clk);
        timer1_overflow = 1'b0;
    endtask : tick

    initial begin
        repeat (50000) @(posedge clk);
        fail_count++;
        $display("MISMATCH t=%0t run did not finish", $time);
        end_of_test();
    end

    initial begin
        cyc(10);
        arst_n = 1'b1;
        rdc(`CEC_ADDR_CONTROL, `CEC_CONTROL_RESET);
        rdc(`CEC_ADDR_INPUT_SEL, `CEC_INPUT_SEL_RESET);
        rdc(8'h55, 8'h00);
        outc(3'b000, 3'b111);
        $display("reset test done");
        for (int i = 0; i < 16; i++) begin
            v = $random(seed);
            v[7:4] = 4'(i);
            v[1:0] = 2'(i);
            u_cec_cpu_model.wr(`CEC_ADDR_INPUT_SEL, v);
            rdc(`CEC_ADDR_INPUT_SEL, v & `CEC_INPUT_SEL_WMASK);
            note({11'h000, v[1:0], v[7:4]}, 17'h0003f);
        end
        $display("select test done");
        setraw(1'b1);
        wc(8'h27);
        cyc(6);
        rdc(`CEC_ADDR_CONTROL, 8'h07);
        outc(3'b000, 3'b001);
        $display("disable test done");
        for (int k = 0; k < 8; k++) begin
            logic s, lv, db;
            lv = (k == 0) || (k == 7);
            db = (k == 2) || (k == 3) || (k == 6);
            s  = (k == 4) || (k == 6) || (k == 7);
            setraw(s);
            wc(8'h00);
            cyc(6);
            wc(8'h08 | 8'(k));
            cyc(6);
            wc(8'h08 | 8'(k));
            rdc(`CEC_ADDR_CONTROL, {2'b00, s, lv, 1'b1, 3'(k)});
            if (!lv) begin
                setraw(~s);
                cyc(6);
                if (db) begin
                    tick();
                    rdc(`CEC_ADDR_CONTROL, {2'b00, ~s, 1'b0, 1'b1, 3'(k)});
                    tick();
                    cyc(4);
                end
                rdc(`CEC_ADDR_CONTROL, {2'b00, ~s, 1'b1, 1'b1, 3'(k)});
            end
            $display("mode %0d test done", k);
        end
        // Glitch shorter than the debounce window is dropped
        setraw(1'b0);
        wc(8'h00);
        cyc(6);
        wc(8'h0b);
        cyc(6);
        setraw(1'b1);
        cyc(6);
        setraw(1'b0);
        cyc(6);
        tick();
        tick();
        cyc(4);
        rdc(`CEC_ADDR_CONTROL, 8'h0b);
        $display("debounce test done");
        setraw(1'b1);
        u_cec_cpu_model.irq_on(8'hcf);
        cyc(4);
        outc(3'b101, 3'b111);
        @(negedge clk);
        idle_mode = 1'b1;
        cyc(4);
        outc(3'b111, 3'b111);
        wc(8'h4f);
        cyc(4);
        outc(3'b000, 3'b011);
        @(negedge clk);
        idle_mode = 1'b0;
        powerdown_mode = 1'b1;
        cyc(4);
        outc(3'b111, 3'b111);
        wc(8'h59);
        cyc(4);
        outc(3'b100, 3'b110);
        wc(8'h8f);
        cyc(4);
        outc(3'b000, 3'b011);
        u_cec_cpu_model.ie_set(8'h00);
        cyc(4);
        outc(3'b000, 3'b100);
        $display("irq and wake test done");
        end_of_test();
    end
endmodule : test_comparator_event_control
